/* File: include/hv_output_driver_regs.vh */
// Constants for the serial-to-parallel output driver
//
// Notes on behaviour
// R01: Thirty-two shift stages and thirty-two latches, one per output.
// R02: Each active shift clock edge shifts stages along, loading serial input; edges arriving while shiftHold has the 16-bit buffer full are dropped.
// R03: Output one comes from stage one via latch and polarity logic.
// R04: Serial output shows last stage, independent of latch and polarity.
// R05: Shifting ignores latch strobe, blanking and polarity inputs.
// R06: Latch strobe high makes latches transparent to the shift register.
// R07: Latch strobe low holds latch contents despite further shifting.
// R08: Blanking low with polarity low drives every output high.
// R09: Blanking low with polarity high drives every output low.
// R10: Blanking high, polarity low: outputs show complemented latch contents.
// R11: Blanking and polarity high: outputs show latch contents unchanged.
// R12: Contents undefined at power-up; controller loads and strobes first.
`ifndef HV_OUTPUT_DRIVER_REGS_VH
`define HV_OUTPUT_DRIVER_REGS_VH

`define HVD_CHANNELS      32
`define HVD_FIFO_DEPTH    16
`define HVD_FIFO_ADDR_W   4
`define HVD_SHIFT_RESET   32'h00000000
`define HVD_SYNC_RESET    2'h0
`define HVD_POL_SYNC_RESET 2'h3

`endif

/* File: rtl/hv_output_driver.v */
// Serial-to-parallel output driver with bit FIFO, latches and polarity logic
`timescale 1ns/10ps
`default_nettype none
`include "hv_output_driver_regs.vh"

////////////////////////////////////////////////////////////////////////////
module bit_fifo #(
    parameter WIDTH  = 1,
    parameter DEPTH  = `HVD_FIFO_DEPTH,
    parameter ADDR_W = `HVD_FIFO_ADDR_W
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // Filling side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Draining side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0]  mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wrPtr_reg;
    reg [ADDR_W-1:0] rdPtr_reg;
    reg [ADDR_W:0]   count_reg;
    wire             doWrite;
    wire             doRead;
    reg [ADDR_W-1:0] wrPtr_next;
    reg [ADDR_W-1:0] rdPtr_next;
    reg [ADDR_W:0]   count_next;

    assign inReady  = (count_reg != DEPTH[ADDR_W:0]);
    assign outValid = (count_reg != {(ADDR_W+1){1'b0}});
    assign outData  = mem[rdPtr_reg];
    assign doWrite  = inValid & inReady;
    assign doRead   = outValid & outReady;

    always @(posedge clock) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always @* begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (doWrite) begin
            wrPtr_next = wrPtr_reg + 1'b1;
        end
        if (doRead) begin
            rdPtr_next = rdPtr_reg + 1'b1;
        end
        if (doWrite & ~doRead) begin
            count_next = count_reg + 1'b1;
        end else if (doRead & ~doWrite) begin
            count_next = count_reg - 1'b1;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_reg <= {ADDR_W{1'b0}};
            rdPtr_reg <= {ADDR_W{1'b0}};
            count_reg <= {(ADDR_W+1){1'b0}};
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module hv_output_driver #(
    parameter CHANNELS = `HVD_CHANNELS
) (
    // Clock and reset
    input  wire                clock,
    input  wire                rst_n,
    // Controller pins, asynchronous to clock
    input  wire                shiftClock,
    input  wire                serialIn,
    input  wire                latch_strobe_n,
    input  wire                blank_n,
    input  wire                polarity_sel,
    // Local stall of the shift stage
    input  wire                shiftHold,
    // Driven outputs
    output reg  [CHANNELS-1:0] hv_output,
    output reg                 serialOut,
    output reg                 bufferReady
);
    // Two-flop synchronisers; stage one read only by stage two
    reg [1:0] clkSync_reg;
    reg [1:0] dataSync_reg;
    reg [1:0] strobeSync_reg;
    reg [1:0] blankSync_reg;
    reg [1:0] polSync_reg;
    reg       clkPrev_reg;
    reg [CHANNELS-1:0] shift_reg;
    reg [CHANNELS-1:0] latch_reg;
    reg [CHANNELS-1:0] shift_next;
    reg [CHANNELS-1:0] latch_next;
    reg [CHANNELS-1:0] hvOutput_next;
    wire      clkRise;
    wire      fifoInReady;
    wire      fifoOutValid;
    wire      fifoOutData;
    wire      popBit;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clkSync_reg    <= `HVD_SYNC_RESET;
            dataSync_reg   <= `HVD_SYNC_RESET;
            strobeSync_reg <= `HVD_SYNC_RESET;
            blankSync_reg  <= `HVD_SYNC_RESET;
            // Blanked and all low from reset: no flash of every output
            polSync_reg    <= `HVD_POL_SYNC_RESET;
            clkPrev_reg    <= 1'b0;
        end else begin
            clkSync_reg    <= {clkSync_reg[0], shiftClock};
            dataSync_reg   <= {dataSync_reg[0], serialIn};
            strobeSync_reg <= {strobeSync_reg[0], latch_strobe_n};
            blankSync_reg  <= {blankSync_reg[0], blank_n};
            polSync_reg    <= {polSync_reg[0], polarity_sel};
            clkPrev_reg    <= clkSync_reg[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // R02: rising shift edge
    // Rising edge taken: set-up and hold are quoted against it
    assign clkRise = clkSync_reg[1] & ~clkPrev_reg;

    // Buffer absorbs edges while the shift stage is held
    bit_fifo #(
        .WIDTH  (1),
        .DEPTH  (`HVD_FIFO_DEPTH),
        .ADDR_W (`HVD_FIFO_ADDR_W)
    ) bitBuffer (
        .clock    (clock),
        .rst_n    (rst_n),
        .inValid  (clkRise),
        .inReady  (fifoInReady),
        .inData   (dataSync_reg[1]),
        .outValid (fifoOutValid),
        .outReady (~shiftHold),
        .outData  (fifoOutData)
    );

    assign popBit = fifoOutValid & ~shiftHold;

    // R01: thirty-two stages
    // R05: shifting ignores strobe, blanking, polarity
    always @* begin
        shift_next = shift_reg;
        if (popBit) begin
            shift_next = {shift_reg[CHANNELS-2:0], fifoOutData};
        end
    end

    // R12: reset value only for simulation tidiness
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= `HVD_SHIFT_RESET;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // R06: transparent while strobe high
    // R07: hold while strobe low
    always @* begin
        latch_next = latch_reg;
        if (strobeSync_reg[1]) begin
            latch_next = shift_reg;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= `HVD_SHIFT_RESET;
        end else begin
            latch_reg <= latch_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Polarity and blanking per channel
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : chanLogic
            // R03: channel ch from stage ch
            always @* begin
                case ({blankSync_reg[1], polSync_reg[1]})
                    // R08: all high
                    2'h0: hvOutput_next[ch] = 1'b1;
                    // R09: all low
                    2'h1: hvOutput_next[ch] = 1'b0;
                    // R10: inverted latch
                    2'h2: hvOutput_next[ch] = ~latch_reg[ch];
                    // R11: latch unchanged
                    default: hvOutput_next[ch] = latch_reg[ch];
                endcase
            end
        end
    endgenerate

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hv_output   <= `HVD_SHIFT_RESET;
            serialOut   <= 1'b0;
            bufferReady <= 1'b0;
        end else begin
            hv_output   <= hvOutput_next;
            // R04: last stage to cascade
            serialOut   <= shift_reg[CHANNELS-1];
            bufferReady <= fifoInReady;
        end
    end
endmodule

`default_nettype wire

/* File: test/display_controller_model.sv */
// Behavioural display controller feeding the serial pins
`timescale 1ns/10ps
`default_nettype none
module display_controller_model (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic     shiftClock = 1'b0,
    output logic     serialIn = 1'b0
);
    integer k;
    // whole word, first bit ends at the last stage
    task send(input logic [31:0] w);
        for (k = 31; k >= 0; k--) begin
            @(posedge clock) #1 serialIn = w[k];
            repeat (4) @(posedge clock);
            #1 shiftClock = 1'b1;
            repeat (4) @(posedge clock);
            #1 shiftClock = 1'b0;
            // Stale data would hide a late sample
            serialIn = ~w[k];
        end
    endtask
endmodule
`default_nettype wire

/* File: test/hv_output_driver_bench.sv */
// Self-checking bench for the output driver
`timescale 1ns/10ps
`default_nettype none
module hv_output_driver_bench;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        latch_strobe_n = 1'b1;
    logic        blank_n = 1'b0;
    logic        polarity_sel = 1'b1;
    logic        shiftHold = 1'b0;
    wire         shiftClock, serialIn, serialOut, bufferReady;
    wire  [31:0] hv_output;
    logic [31:0] expQ[$];
    logic [31:0] seed = 32'h5D;
    logic [31:0] w1, w2;
    integer      nMismatch = 0, checked = 0, m;
    event        look;
    always #5 clock = ~clock;
    hv_output_driver hv_output_driver_i (.clock(clock), .rst_n(rst_n),
        .shiftClock(shiftClock), .serialIn(serialIn),
        .latch_strobe_n(latch_strobe_n), .blank_n(blank_n),
        .polarity_sel(polarity_sel), .shiftHold(shiftHold),
        .hv_output(hv_output), .serialOut(serialOut),
        .bufferReady(bufferReady));
    display_controller_model display_controller_model_i (.clock(clock),
        .shiftClock(shiftClock), .serialIn(serialIn));
    function logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task pins(input logic l, input logic b, input logic p);
        @(posedge clock) #1;
        latch_strobe_n = l;
        blank_n = b;
        polarity_sel = p;
    endtask
    task expectHv(input logic [31:0] v);
        expQ.push_back(v);
        // Long enough for a sixteen-bit drain
        repeat (24) @(posedge clock);
        #1 -> look;
    endtask
    task finish_test;
        $display("checked %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(look) cmp(hv_output, expQ.pop_front());
    initial begin
        #100000;
        nMismatch++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge clock);
        #1 rst_n = 1'b1;
        w1 = xorshift();
        w2 = xorshift();
        display_controller_model_i.send(w1);
        pins(1'b1, 1'b1, 1'b1);
        expectHv(w1);
        pins(1'b0, 1'b1, 1'b1);
        display_controller_model_i.send(w2);
        // Every mode while the latch holds the old word
        for (m = 0; m < 4; m++) begin
            pins(1'b0, m[1], m[0]);
            expectHv(m == 0 ? '1 : m == 1 ? '0 : m == 2 ? ~w1 : w1);
        end
        pins(1'b1, 1'b1, 1'b1);
        expectHv(w2);
        shiftHold = 1'b1;
        display_controller_model_i.send(w1);
        // Sixteen bits queued, the rest refused
        cmp({31'h0, bufferReady}, 32'h0);
        shiftHold = 1'b0;
        expectHv({w2[15:0], w1[31:16]});
        cmp({31'h0, bufferReady}, 32'h1);
        pins(1'b1, 1'b1, 1'b0);
        display_controller_model_i.send(w2);
        expectHv(~w2);
        @(posedge clock);
        finish_test;
    end
endmodule
bind hv_output_driver hv_output_driver_props #(.CHANNELS(CHANNELS))
    hv_output_driver_props_i (.clock(clock), .rst_n(rst_n),
    .latch_strobe_n(latch_strobe_n), .blank_n(blank_n),
    .polarity_sel(polarity_sel), .hv_output(hv_output),
    .serialOut(serialOut));
`default_nettype wire

/* File: test/hv_output_driver_props.sv */
// Concurrent checks on the output driver pins
`timescale 1ns/10ps
`default_nettype none
module hv_output_driver_props #(
    parameter CHANNELS = 32
) (
    // Clock and reset
    input wire logic                clock,
    input wire logic                rst_n,
    // Controller pins
    input wire logic                latch_strobe_n,
    input wire logic                blank_n,
    input wire logic                polarity_sel,
    // Driven outputs
    input wire logic [CHANNELS-1:0] hv_output,
    input wire logic                serialOut
);
    // Six or eight steady cycles cover the pin synchronisers
    wire tru = latch_strobe_n && blank_n && polarity_sel;
    wire inv = latch_strobe_n && blank_n && !polarity_sel;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_all_high: assert property (
        (!blank_n && !polarity_sel)[*6] |-> &hv_output) else $error("high");
    a_all_low: assert property (
        (!blank_n && polarity_sel)[*6] |-> hv_output == 0) else $error("low");
    a_latch_hold: assert property (
        (!latch_strobe_n && $stable({blank_n, polarity_sel}))[*8]
        |-> $stable(hv_output)) else $error("hold");
    a_true_tail: assert property (
        tru[*8] |-> hv_output[CHANNELS-1] == $past(serialOut))
        else $error("tail");
    a_invert_tail: assert property (
        inv[*8] |-> hv_output[CHANNELS-1] == !$past(serialOut))
        else $error("invert");
    a_shift_chain: assert property (
        tru[*8] ##0 $changed(hv_output) |-> hv_output[CHANNELS-1:1]
        == $past(hv_output[CHANNELS-2:0])) else $error("chain");
    a_tail_timing: assert property (
        tru[*8] ##0 $changed(serialOut) |=> $changed(hv_output[CHANNELS-1]))
        else $error("transparent");
    a_reset_clear: assert property (disable iff (1'b0)
        !rst_n |=> hv_output == 0 && !serialOut) else $error("reset");
endmodule
`default_nettype wire
